//--- src/access_timer.sv
// up-counting access timer that flags an uncompleted reconfiguration access
`timescale 1ns/1ps
module access_timer
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic arm,
   input wire logic run,
   input wire logic enable,
   input wire logic [lane_timeout_pkg::TMO_VAL_W-1:0] limit,
   output logic expired
);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   localparam logic [lane_timeout_pkg::TMO_VAL_W-1:0] CNT_MAX = '1;

   logic [lane_timeout_pkg::TMO_VAL_W-1:0] cnt_r;
   logic [lane_timeout_pkg::TMO_VAL_W-1:0] cnt_nxt;
   logic expired_r;
   logic expired_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      expired_nxt = 1'b0;
      if (arm)
      begin
         cnt_nxt = '0;
      end
      else if (run)
      begin
         // saturate so a disabled timer never wraps into a false match
         if (cnt_r != CNT_MAX)
         begin
            cnt_nxt = cnt_r + 1'b1;
         end
         // flag is registered, so the answer lands limit + 2 cycles after the arm
         expired_nxt = enable && (cnt_r == limit);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         expired_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign expired = expired_r;

endmodule : access_timer

//--- src/lane_enum_and_access_timeout.sv
// axi4-lite register bank: lane and shared pll counts, selectors, access timeout, reconfiguration port stretch
//
// Function
// - a read of the shared pll count register returns the number of shared pll blocks, about one per four lanes.
// - a read of the lane count register returns the number of lane transceiver blocks, equal to the lane count.
// - bit 0 of the timeout enable register turns the access timeout on or off and resets to one.
// - an access ended by the timeout answers with a slave error response.
// - the low twelve bits of the timeout value register, reset 128, set the wait in axi clock cycles.
// - the timeout counter counts upward from zero to the field value, so software programs the wanted length minus two.
// - the whole timeout is the field value plus two cycles, and only 0 to 4094 may be programmed.
// - an access to the reconfiguration port holds its axi answer until the port access completes or the access timeout ends it.
`timescale 1ns/1ps
module lane_enum_and_access_timeout
#(
   parameter int NUM_LANES = 4,
   parameter int NUM_SHARED_PLL = (NUM_LANES + lane_timeout_pkg::LANES_PER_SHARED_PLL - 1) /
                                  lane_timeout_pkg::LANES_PER_SHARED_PLL
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [lane_timeout_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [lane_timeout_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [lane_timeout_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [lane_timeout_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic reconfiguration_port_req,
   output logic reconfiguration_port_we,
   output logic [lane_timeout_pkg::ADDR_W-1:0] reconfiguration_port_addr,
   output logic [lane_timeout_pkg::DATA_W-1:0] reconfiguration_port_wdata,
   input wire logic reconfiguration_port_ack,
   input wire logic [lane_timeout_pkg::DATA_W-1:0] reconfiguration_port_rdata,
   output logic [lane_timeout_pkg::PLL_SEL_W-1:0] common_block_select,
   output logic [lane_timeout_pkg::LANE_SEL_W-1:0] lane_select
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic in_port_window(input logic [lane_timeout_pkg::ADDR_W-1:0] a);
      in_port_window = (a >= lane_timeout_pkg::PORT_WIN_LO) && (a <= lane_timeout_pkg::PORT_WIN_HI);
   endfunction : in_port_window

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
      begin
         merge_bytes[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
   endfunction : merge_bytes

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // bus state machine and registers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_WTAKE, ST_RTAKE, ST_PORT, ST_BRESP, ST_RRESP} bus_state_e;

   localparam logic [31:0] SHARED_PLL_COUNT = 32'(NUM_SHARED_PLL);
   localparam logic [31:0] LANE_COUNT = 32'(NUM_LANES);

   bus_state_e state_r, state_nxt;
   logic port_write_r, port_write_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic arready_r, arready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic preq_r, preq_nxt;
   logic [lane_timeout_pkg::ADDR_W-1:0] paddr_r, paddr_nxt;
   logic [31:0] pwdata_r, pwdata_nxt;
   logic tmo_en_r, tmo_en_nxt;
   logic [lane_timeout_pkg::TMO_VAL_W-1:0] tmo_val_r, tmo_val_nxt;
   logic [lane_timeout_pkg::PLL_SEL_W-1:0] pll_sel_r, pll_sel_nxt;
   logic [lane_timeout_pkg::LANE_SEL_W-1:0] lane_sel_r, lane_sel_nxt;
   logic timer_arm;
   logic [1:0] end_resp;
   logic timer_expired;
   logic [31:0] merged;

   access_timer u_timer
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .arm(timer_arm),
      .run(state_r == ST_PORT),
      .enable(tmo_en_r),
      .limit(tmo_val_r),
      .expired(timer_expired)
   );

   always_comb
   begin
      state_nxt = state_r;
      port_write_nxt = port_write_r;
      awready_nxt = 1'b0;
      wready_nxt = 1'b0;
      arready_nxt = 1'b0;
      bvalid_nxt = bvalid_r;
      rvalid_nxt = rvalid_r;
      bresp_nxt = bresp_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      preq_nxt = 1'b0;
      paddr_nxt = paddr_r;
      pwdata_nxt = pwdata_r;
      tmo_en_nxt = tmo_en_r;
      tmo_val_nxt = tmo_val_r;
      pll_sel_nxt = pll_sel_r;
      lane_sel_nxt = lane_sel_r;
      timer_arm = 1'b0;
      end_resp = lane_timeout_pkg::RESP_OKAY;
      merged = '0;
      unique case (state_r)
         ST_IDLE:
         begin
            // writes win over reads when both arrive together
            if (s_axi_awvalid && s_axi_wvalid)
            begin
               awready_nxt = 1'b1;
               wready_nxt = 1'b1;
               state_nxt = ST_WTAKE;
            end
            else if (s_axi_arvalid)
            begin
               arready_nxt = 1'b1;
               state_nxt = ST_RTAKE;
            end
         end
         ST_WTAKE:
         begin
            bresp_nxt = lane_timeout_pkg::RESP_OKAY;
            if (in_port_window(s_axi_awaddr))
            begin
               preq_nxt = 1'b1;
               port_write_nxt = 1'b1;
               paddr_nxt = s_axi_awaddr;
               pwdata_nxt = s_axi_wdata;
               timer_arm = 1'b1;
               state_nxt = ST_PORT;
            end
            else
            begin
               bvalid_nxt = 1'b1;
               state_nxt = ST_BRESP;
               unique case (s_axi_awaddr)
                  lane_timeout_pkg::OFF_ACCESS_TIMEOUT_ENABLE:
                  begin
                     merged = merge_bytes({31'h0, tmo_en_r}, s_axi_wdata, s_axi_wstrb);
                     tmo_en_nxt = merged[lane_timeout_pkg::TMO_EN_BIT];
                  end
                  lane_timeout_pkg::OFF_ACCESS_TIMEOUT_VALUE:
                  begin
                     merged = merge_bytes({20'h0, tmo_val_r}, s_axi_wdata, s_axi_wstrb);
                     tmo_val_nxt = merged[lane_timeout_pkg::TMO_VAL_W-1:0];
                  end
                  lane_timeout_pkg::OFF_COMMON_BLOCK_SELECT:
                  begin
                     merged = merge_bytes({30'h0, pll_sel_r}, s_axi_wdata, s_axi_wstrb);
                     pll_sel_nxt = merged[lane_timeout_pkg::PLL_SEL_W-1:0];
                  end
                  lane_timeout_pkg::OFF_LANE_SELECT:
                  begin
                     merged = merge_bytes({28'h0, lane_sel_r}, s_axi_wdata, s_axi_wstrb);
                     lane_sel_nxt = merged[lane_timeout_pkg::LANE_SEL_W-1:0];
                  end
                  default: merged = '0;
               endcase
            end
         end
         ST_RTAKE:
         begin
            rresp_nxt = lane_timeout_pkg::RESP_OKAY;
            if (in_port_window(s_axi_araddr))
            begin
               preq_nxt = 1'b1;
               port_write_nxt = 1'b0;
               paddr_nxt = s_axi_araddr;
               timer_arm = 1'b1;
               state_nxt = ST_PORT;
            end
            else
            begin
               rvalid_nxt = 1'b1;
               state_nxt = ST_RRESP;
               unique case (s_axi_araddr)
                  lane_timeout_pkg::OFF_SHARED_PLL_BLOCK_COUNT: rdata_nxt = SHARED_PLL_COUNT;
                  lane_timeout_pkg::OFF_LANE_TRANSCEIVER_COUNT: rdata_nxt = LANE_COUNT;
                  lane_timeout_pkg::OFF_ACCESS_TIMEOUT_ENABLE: rdata_nxt = {31'h0, tmo_en_r};
                  lane_timeout_pkg::OFF_ACCESS_TIMEOUT_VALUE: rdata_nxt = {20'h0, tmo_val_r};
                  lane_timeout_pkg::OFF_COMMON_BLOCK_SELECT: rdata_nxt = {30'h0, pll_sel_r};
                  lane_timeout_pkg::OFF_LANE_SELECT: rdata_nxt = {28'h0, lane_sel_r};
                  default: rdata_nxt = '0;
               endcase
            end
         end
         ST_PORT:
         begin
            // completion beats an expiry seen in the same cycle; a late ack after expiry is dropped
            if (reconfiguration_port_ack || timer_expired)
            begin
               end_resp = reconfiguration_port_ack ? lane_timeout_pkg::RESP_OKAY :
                  lane_timeout_pkg::RESP_SLVERR;
               if (port_write_r)
               begin
                  bresp_nxt = end_resp;
                  bvalid_nxt = 1'b1;
                  state_nxt = ST_BRESP;
               end
               else
               begin
                  rdata_nxt = reconfiguration_port_ack ? reconfiguration_port_rdata : '0;
                  rresp_nxt = end_resp;
                  rvalid_nxt = 1'b1;
                  state_nxt = ST_RRESP;
               end
            end
         end
         ST_BRESP:
         begin
            if (s_axi_bready)
            begin
               bvalid_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         ST_RRESP:
         begin
            if (s_axi_rready)
            begin
               rvalid_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         port_write_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         arready_r <= 1'b0;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         bresp_r <= lane_timeout_pkg::RESP_OKAY;
         rresp_r <= lane_timeout_pkg::RESP_OKAY;
         rdata_r <= '0;
         preq_r <= 1'b0;
         paddr_r <= '0;
         pwdata_r <= '0;
         tmo_en_r <= lane_timeout_pkg::RST_TMO_EN;
         tmo_val_r <= lane_timeout_pkg::RST_TMO_VAL;
         pll_sel_r <= lane_timeout_pkg::RST_PLL_SEL;
         lane_sel_r <= lane_timeout_pkg::RST_LANE_SEL;
      end
      else
      begin
         state_r <= state_nxt;
         port_write_r <= port_write_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
         bvalid_r <= bvalid_nxt;
         rvalid_r <= rvalid_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         preq_r <= preq_nxt;
         paddr_r <= paddr_nxt;
         pwdata_r <= pwdata_nxt;
         tmo_en_r <= tmo_en_nxt;
         tmo_val_r <= tmo_val_nxt;
         pll_sel_r <= pll_sel_nxt;
         lane_sel_r <= lane_sel_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign reconfiguration_port_req = preq_r;
   assign reconfiguration_port_we = port_write_r;
   assign reconfiguration_port_addr = paddr_r;
   assign reconfiguration_port_wdata = pwdata_r;
   assign common_block_select = pll_sel_r;
   assign lane_select = lane_sel_r;

endmodule : lane_enum_and_access_timeout

//--- src/lane_timeout_pkg.sv
// register map, field layouts, reset values and response codes of the lane enumeration and timeout bank
package lane_timeout_pkg;

   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_SHARED_PLL_BLOCK_COUNT = 12'h008;
   localparam logic [11:0] OFF_LANE_TRANSCEIVER_COUNT = 12'h00c;
   localparam logic [11:0] OFF_ACCESS_TIMEOUT_ENABLE = 12'h010;
   localparam logic [11:0] OFF_ACCESS_TIMEOUT_VALUE = 12'h014;
   localparam logic [11:0] OFF_COMMON_BLOCK_SELECT = 12'h020;
   localparam logic [11:0] OFF_LANE_SELECT = 12'h024;

   // reconfiguration port window, both mailboxes
   localparam logic [11:0] PORT_WIN_LO = 12'h100;
   localparam logic [11:0] PORT_WIN_HI = 12'h2ff;

   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   localparam int TMO_EN_BIT = 0;
   localparam int TMO_VAL_W = 12;
   localparam int PLL_SEL_W = 2;
   localparam int LANE_SEL_W = 4;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_TMO_EN = 1'b1;
   localparam logic [11:0] RST_TMO_VAL = 12'h080;
   localparam logic [1:0] RST_PLL_SEL = 2'h0;
   localparam logic [3:0] RST_LANE_SEL = 4'h0;

   // ----------------------------------------------------------------
   // responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // lanes served by one shared pll block
   // ----------------------------------------------------------------
   localparam int LANES_PER_SHARED_PLL = 4;

endpackage : lane_timeout_pkg

//--- test/lane_timeout_assertions.sv
// port checks of the lane enumeration and access timeout bank
`timescale 1ns/1ps
module lane_timeout_checker
#(
   parameter int NUM_LANES = 4,
   parameter int NUM_SHARED_PLL = 1
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic reconfiguration_port_req,
   input wire logic reconfiguration_port_ack
);
   // ----------
   // mirror of the timeout settings and a wait counter
   // ----------
   logic pend_r, pend_nxt, en_r, en_nxt, done, err, win;
   logic [11:0] val_r, val_nxt;
   logic [12:0] cnt_r, cnt_nxt;
   assign done = s_axi_bvalid | s_axi_rvalid;
   assign err = (s_axi_bvalid ? s_axi_bresp : s_axi_rresp) == lane_timeout_pkg::RESP_SLVERR;
   assign win = (s_axi_awready && s_axi_awaddr[11:8] inside {4'h1, 4'h2}) ||
                (s_axi_arready && s_axi_araddr[11:8] inside {4'h1, 4'h2});
   always_comb
   begin
      pend_nxt = reconfiguration_port_req | (pend_r & ~done);
      cnt_nxt = reconfiguration_port_req ? 13'h1 : cnt_r + {12'h0, pend_r};
      en_nxt = en_r;
      val_nxt = val_r;
      if (s_axi_awready && s_axi_awaddr == lane_timeout_pkg::OFF_ACCESS_TIMEOUT_ENABLE && s_axi_wstrb[0])
         en_nxt = s_axi_wdata[0];
      if (s_axi_awready && s_axi_awaddr == lane_timeout_pkg::OFF_ACCESS_TIMEOUT_VALUE && s_axi_wstrb[0])
         val_nxt[7:0] = s_axi_wdata[7:0];
      if (s_axi_awready && s_axi_awaddr == lane_timeout_pkg::OFF_ACCESS_TIMEOUT_VALUE && s_axi_wstrb[1])
         val_nxt[11:8] = s_axi_wdata[11:8];
   end
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pend_r <= 1'b0;
         cnt_r <= 13'h0;
         en_r <= 1'b1;
         val_r <= 12'h080;
      end
      else
      begin
         pend_r <= pend_nxt;
         cnt_r <= cnt_nxt;
         en_r <= en_nxt;
         val_r <= val_nxt;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_pll_count_read: assert property (s_axi_arready && s_axi_araddr == 12'h008
      |=> s_axi_rvalid && s_axi_rdata == 32'(NUM_SHARED_PLL)) else $error("shared pll count wrong");
   a_lane_count_read: assert property (s_axi_arready && s_axi_araddr == 12'h00c
      |=> s_axi_rvalid && s_axi_rdata == 32'(NUM_LANES)) else $error("lane count wrong");
   a_local_write_ok: assert property (s_axi_awready && s_axi_awaddr < 12'h100
      |=> s_axi_bvalid && s_axi_bresp == 2'h0) else $error("local write not answered okay");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped early");
   a_port_start: assert property (win |=> reconfiguration_port_req) else $error("port access not started");
   a_ack_answers_okay: assert property (pend_r && reconfiguration_port_ack && !done |=> done && !err)
      else $error("ack not answered okay");
   a_timeout_exact: assert property (pend_r && done && err |-> en_r && cnt_r == val_r + 13'd2)
      else $error("timeout length wrong");
   a_wait_bounded: assert property (pend_r && en_r |-> cnt_r <= val_r + 13'd2)
      else $error("wait ran past the timeout");
   a_disabled_okay: assert property (pend_r && done && !en_r |-> !err) else $error("error while timeout off");
   c_timeout: cover property (pend_r && done && err);
   c_ack: cover property (pend_r && reconfiguration_port_ack);
   c_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : lane_timeout_checker

bind lane_enum_and_access_timeout lane_timeout_checker #(.NUM_LANES(NUM_LANES), .NUM_SHARED_PLL(NUM_SHARED_PLL)) u_chk
(
   .clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .reconfiguration_port_req(reconfiguration_port_req), .reconfiguration_port_ack(reconfiguration_port_ack)
);

//--- test/port_responder.sv
// behavioural reconfiguration port target with adjustable ack delay
`timescale 1ns/1ps
module port_responder
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic req,
   input wire logic we,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [7:0] delay,
   input wire logic mute,
   output logic ack,
   output logic [31:0] rdata
);
   logic [31:0] mem [0:255];
   logic [7:0] wait_r;
   logic busy_r;
   // mute models an unclocked transceiver: no ack ever comes
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         busy_r <= 1'b0;
         wait_r <= 8'h0;
         ack <= 1'b0;
         rdata <= 32'h0;
      end
      else
      begin
         ack <= 1'b0;
         rdata <= ~rdata;
         if (req)
         begin
            busy_r <= 1'b1;
            wait_r <= delay;
         end
         else if (busy_r && !mute && wait_r <= 8'h1)
         begin
            busy_r <= 1'b0;
            ack <= 1'b1;
            rdata <= mem[addr[9:2]];
            if (we)
               mem[addr[9:2]] <= wdata;
         end
         else if (busy_r && !mute)
            wait_r <= wait_r - 8'h1;
      end
   end
endmodule : port_responder

//--- test/tb_top.sv
// self-checking bench for the lane enumeration and access timeout bank
`timescale 1ns/1ps
module tb_top;
   localparam int LANES = 8;
   localparam int PLLS = 2;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, mute = 1'b0;
   logic [7:0] delay = 8'h1;
   logic awready, wready, bvalid, arready, rvalid, req, we, ack;
   logic [1:0] bresp, rresp, pll_sel, resp;
   logic [3:0] lane_sel;
   logic [11:0] paddr;
   logic [31:0] rdata, pwdata, prdata, got;
   int err_count = 0, tests_run = 0, lat;
   int tlen [3] = '{4096, 4095, 2};
   always #5 clk_sys = ~clk_sys;
   lane_enum_and_access_timeout #(.NUM_LANES(LANES), .NUM_SHARED_PLL(PLLS)) uut
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reconfiguration_port_req(req),
      .reconfiguration_port_we(we), .reconfiguration_port_addr(paddr), .reconfiguration_port_wdata(pwdata),
      .reconfiguration_port_ack(ack), .reconfiguration_port_rdata(prdata), .common_block_select(pll_sel),
      .lane_select(lane_sel)
   );
   port_responder far_end
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .req(req), .we(we), .addr(paddr), .wdata(pwdata),
      .delay(delay), .mute(mute), .ack(ack), .rdata(prdata)
   );
   // ----------
   // compare, wait and bus tasks
   // ----------
   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t data %h expected %h", $time, g, e);
      end
   endtask : chk_data
   task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t resp %h expected %h", $time, g, e);
      end
   endtask : chk_resp
   task automatic chk_lat(input int g, input int e);
      tests_run++;
      if (g != e)
      begin
         err_count++;
         $display("MISMATCH t=%0t latency %0d expected %0d", $time, g, e);
      end
   endtask : chk_lat
   // counts edges until the masked answer is sampled high
   task automatic wait_hi(input logic [3:0] m, output int n);
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (({rvalid, bvalid, arready, awready} & m) !== m && n < 5000);
      if (n >= 5000)
         chk_lat(n, 0);
   endtask : wait_hi
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r,
                     output int l);
      int n;
      @(posedge clk_sys);
      #1;
      awaddr = a;
      wdata = d;
      wstrb = s;
      awvalid = 1'b1;
      wvalid = 1'b1;
      wait_hi(4'h1, n);
      #1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      awaddr = ~a;
      wdata = ~d;
      wait_hi(4'h4, l);
      r = bresp;
      #1;
      bready = 1'b1;
      @(posedge clk_sys);
      #1;
      bready = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r, output int l);
      int n;
      @(posedge clk_sys);
      #1;
      araddr = a;
      arvalid = 1'b1;
      wait_hi(4'h2, n);
      #1;
      arvalid = 1'b0;
      araddr = ~a;
      wait_hi(4'h8, l);
      d = rdata;
      r = rresp;
      #1;
      rready = 1'b1;
      @(posedge clk_sys);
      #1;
      rready = 1'b0;
   endtask : rd
   task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      wr(a, d, s, resp, lat);
      chk_resp(resp, e);
   endtask : wr_chk
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a, got, resp, lat);
      chk_data(got, e);
      chk_resp(resp, er);
   endtask : rd_chk
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // ----------
   // sequence
   // ----------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_chk(12'h008, PLLS, 2'h0);
      rd_chk(12'h00c, LANES, 2'h0);
      rd_chk(12'h010, 32'h1, 2'h0);
      rd_chk(12'h014, 32'h80, 2'h0);
      wr_chk(12'h0f0, 32'hffff_ffff, 4'hf, 2'h0);
      rd_chk(12'h0f0, 32'h0, 2'h0);
      wr_chk(12'h020, PLLS - 1, 4'hf, 2'h0);
      wr_chk(12'h024, LANES - 1, 4'hf, 2'h0);
      chk_data({30'h0, pll_sel}, PLLS - 1);
      chk_data({28'h0, lane_sel}, LANES - 1);
      rd_chk(12'h024, LANES - 1, 2'h0);
      // only byte one lands, so the low byte keeps its reset value
      wr_chk(12'h014, 32'h0000_0300, 4'h2, 2'h0);
      rd_chk(12'h014, 32'h380, 2'h0);
      wr_chk(12'h104, 32'h1234_5678, 4'hf, 2'h0);
      delay = 8'd40;
      wr_chk(12'h204, 32'hcafe_f00d, 4'hf, 2'h0);
      rd_chk(12'h104, 32'h1234_5678, 2'h0);
      rd_chk(12'h204, 32'hcafe_f00d, 2'h0);
      mute = 1'b1;
      foreach (tlen[i])
      begin
         wr_chk(12'h014, 4096 - tlen[i], 4'hf, 2'h0);
         wr(12'h108, 32'h1, 4'hf, resp, lat);
         chk_resp(resp, 2'h2);
         chk_lat(lat, 4096 - tlen[i] + 3);
         rd(12'h10c, got, resp, lat);
         chk_resp(resp, 2'h2);
         chk_data(got, 32'h0);
         chk_lat(lat, 4096 - tlen[i] + 3);
      end
      mute = 1'b0;
      delay = 8'd20;
      wr_chk(12'h014, 32'h0, 4'hf, 2'h0);
      wr_chk(12'h010, 32'h0, 4'hf, 2'h0);
      rd_chk(12'h010, 32'h0, 2'h0);
      rd_chk(12'h104, 32'h1234_5678, 2'h0);
      wr_chk(12'h010, 32'h1, 4'hf, 2'h0);
      wr_chk(12'h104, 32'h5, 4'hf, 2'h2);
      repeat (30) @(posedge clk_sys);
      test_done();
   end
   initial
   begin
      #200_000;
      err_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      test_done();
   end
endmodule : tb_top
